/* File: scpc_pkg.sv */
// package of constants and types for the system clock pll control block
// ----------------------------------------------------------------------
// Contract
// [RULE1] dac sampling clock comes from exactly one of three input paths.
// [RULE2] low-freq and crystal paths go through the multiplier pll; only direct bypasses.
// [RULE3] direct input can feed the pll via pre-divider of 1, 2, 4 or 8; code treats direct with pre-divider code 0 (ratio 1) as bypass.
// [RULE4] software keeps phase detector input below 150 mhz via pre-divider.
// [RULE5] software enables the doubler only for inputs below 125 mhz.
// [RULE6] feedback divider accepts any integer from 6 to 255.
// [RULE7] synthesized system clock targets 900 mhz to 1 ghz.
// [RULE8] one phase detector sample per comparison cycle, flagging edge alignment.
// [RULE9] control bit 2 at 0 keeps lock detector active, at 1 disables it.
// [RULE10] lock detector counts consecutive in-phase samples, declares lock at threshold.
// [RULE11] two-bit field selects 128, 256, 512 or 1024 samples, default 128.
// [RULE12] software zeroes stability timer whenever lock detector is disabled.
// [RULE13] control bit 6 picks automatic or manual charge pump current.
// [RULE14] automatic mode ignores manual current field bits 5 to 3.
// [RULE15] manual field gives 125 ua steps from 125 ua to 1 ma, default 500 ua.
// [RULE16] stability timer times out at once when zero, else counts from lock.
// [RULE17] an out-of-phase sample clears the run count and drops lock.
// ----------------------------------------------------------------------
package scpc_pkg;
  // register offsets
  localparam logic [11:0] SCPC_CTRL_OFF      = 12'h100;
  localparam logic [11:0] SCPC_FBDIV_OFF     = 12'h101;
  localparam logic [11:0] SCPC_PATH_OFF      = 12'h102;
  localparam logic [11:0] SCPC_TIMER_OFF     = 12'h106;
  localparam logic [11:0] SCPC_STATUS_OFF    = 12'h10C;
  localparam logic [11:0] SCPC_IRQ_STAT_OFF  = 12'h10D;
  localparam logic [11:0] SCPC_IRQ_MASK_OFF  = 12'h10E;
  // control field positions
  localparam int SCPC_LDIV_LSB   = 0;
  localparam int SCPC_LDDIS_BIT  = 2;
  localparam int SCPC_CPCUR_LSB  = 3;
  localparam int SCPC_CPMAN_BIT  = 6;
  localparam int SCPC_EXTLF_BIT  = 7;
  // path register field positions
  localparam int SCPC_PSEL_LSB   = 0;
  localparam int SCPC_MDIV_LSB   = 2;
  localparam int SCPC_DBL_BIT    = 4;
  // reset values and the feedback divider minimum
  // lock run 128, detector on, automatic pump, manual field code 3 = 500 ua
  localparam logic [7:0]  SCPC_CTRL_RST   = 8'h18;
  localparam logic [7:0]  SCPC_FBDIV_RST  = 8'h28;
  localparam logic [7:0]  SCPC_PATH_RST   = 8'h00;
  localparam logic [19:0] SCPC_TIMER_RST  = 20'h0000A;
  localparam logic [7:0]  SCPC_FB_MIN     = 8'h06;
  // timing: stability timer in ms at the 50 mhz core clock
  localparam int SCPC_CLK_MHZ     = 50;
  localparam int SCPC_MS_US       = 1000;
  localparam int SCPC_CYC_PER_MS  = SCPC_CLK_MHZ * SCPC_MS_US;
  // lock run lengths
  localparam logic [10:0] SCPC_RUN_128 = 11'h080;

  typedef enum logic [1:0] {
    SCPC_PATH_DIRECT = 2'b00,
    SCPC_PATH_LOWF   = 2'b01,
    SCPC_PATH_CRYSTAL_SYNTH_PATH   = 2'b10
  } scpc_path_t;

  typedef enum logic [1:0] {
    SCPC_TMR_IDLE = 2'b00,
    SCPC_TMR_RUN  = 2'b01,
    SCPC_TMR_DONE = 2'b10
  } scpc_tmr_t;

  typedef struct packed {
    scpc_path_t path;
    logic       pll_used;
    logic       doubler_en;
    logic [3:0] pre_div;
    logic [7:0] fb_div;
    logic [3:0] cp_current;
  } scpc_pll_cfg_t;
endpackage

/* File: scpc_top.sv */
// system clock path selection, multiplier pll settings and lock detection
`timescale 1ns/1ps
`default_nettype none
module scpc_top (
  input  wire logic                   core_clk_in,
  input  wire logic                   arst_n_in,
  input  wire logic                   clk_en_in,
  input  wire logic [11:0]            reg_addr_in,
  input  wire logic [7:0]             reg_wdata_in,
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  output logic      [7:0]             reg_rdata_out,
  input  wire logic                   pfd_sample_in,
  input  wire logic                   pfd_in_phase_in,
  output scpc_pkg::scpc_pll_cfg_t     pll_cfg_out,
  output logic                        pll_locked_out,
  output logic                        sysclk_stable_out,
  output logic                        irq_out
);

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  logic [7:0]  ctrl_q;
  logic [7:0]  fbdiv_q;
  logic [7:0]  path_q;
  logic [19:0] timer_q;
  logic [2:0]  irq_stat_q;
  logic [2:0]  irq_mask_q;
  logic [7:0]  rdata_q;

  wire ce      = clk_en_in;
  wire wr_ctrl = reg_wr_in && (reg_addr_in == scpc_pkg::SCPC_CTRL_OFF);
  wire wr_fb   = reg_wr_in && (reg_addr_in == scpc_pkg::SCPC_FBDIV_OFF);
  wire wr_path = reg_wr_in && (reg_addr_in == scpc_pkg::SCPC_PATH_OFF);
  wire wr_t0   = reg_wr_in && (reg_addr_in == scpc_pkg::SCPC_TIMER_OFF);
  wire wr_t1   = reg_wr_in && (reg_addr_in == scpc_pkg::SCPC_TIMER_OFF + 12'h001);
  wire wr_t2   = reg_wr_in && (reg_addr_in == scpc_pkg::SCPC_TIMER_OFF + 12'h002);
  wire wr_ist  = reg_wr_in && (reg_addr_in == scpc_pkg::SCPC_IRQ_STAT_OFF);
  wire wr_imsk = reg_wr_in && (reg_addr_in == scpc_pkg::SCPC_IRQ_MASK_OFF);

  // feedback divider below 6 is clamped so the loop never sees an illegal ratio
  wire [7:0] fb_wr_val = (reg_wdata_in < scpc_pkg::SCPC_FB_MIN) ?
                         scpc_pkg::SCPC_FB_MIN : reg_wdata_in; // RULE6

  // path code 11 is not a path; keep the last legal one instead
  wire       path_ok   = (reg_wdata_in[1:0] != 2'b11); // RULE1

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_q  <= scpc_pkg::SCPC_CTRL_RST;
      fbdiv_q <= scpc_pkg::SCPC_FBDIV_RST;
      path_q  <= scpc_pkg::SCPC_PATH_RST;
      timer_q <= scpc_pkg::SCPC_TIMER_RST;
      irq_mask_q <= 3'h0;
    end else if (ce) begin
      if (wr_ctrl) ctrl_q <= reg_wdata_in;
      if (wr_fb) fbdiv_q <= fb_wr_val;
      if (wr_path && path_ok) path_q <= {3'h0, reg_wdata_in[4:0]};
      if (wr_t0) timer_q[7:0] <= reg_wdata_in;
      if (wr_t1) timer_q[15:8] <= reg_wdata_in;
      if (wr_t2) timer_q[19:16] <= reg_wdata_in[3:0];
      if (wr_imsk) irq_mask_q <= reg_wdata_in[2:0];
    end
  end

  // ----------------------------------------------------------------------
  // path and pll configuration
  // ----------------------------------------------------------------------
  wire scpc_pkg::scpc_path_t path_sel = scpc_pkg::scpc_path_t'(path_q[1:0]);
  wire [1:0] mdiv_code = path_q[scpc_pkg::SCPC_MDIV_LSB +: 2];
  wire       dbl_bit   = path_q[scpc_pkg::SCPC_DBL_BIT];
  wire       pll_used  = (path_sel != scpc_pkg::SCPC_PATH_DIRECT) || (mdiv_code != 2'b00); // RULE2
  // doubler only belongs to the low-freq path; the 125 mhz limit is software's job
  wire       dbl_en    = dbl_bit && (path_sel == scpc_pkg::SCPC_PATH_LOWF); // RULE5
  // pre-divider ratio 1/2/4/8 as one-hot, used when the direct input feeds the pll
  wire [3:0] pre_div   = 4'h1 << mdiv_code; // RULE3
  wire       cp_manual = ctrl_q[scpc_pkg::SCPC_CPMAN_BIT];
  wire [2:0] cp_field  = ctrl_q[scpc_pkg::SCPC_CPCUR_LSB +: 3];
  // auto current: coarse bands on the feedback ratio, manual field unused
  wire [2:0] cp_auto   = (fbdiv_q < 8'h20) ? 3'h1 :
                         (fbdiv_q < 8'h40) ? 3'h3 :
                         (fbdiv_q < 8'h80) ? 3'h5 : 3'h7; // RULE14
  // code k selects (k+1) x 125 ua, so code 3 is 500 ua
  wire [2:0] cp_code   = cp_manual ? cp_field : cp_auto; // RULE13 RULE15

  scpc_pkg::scpc_pll_cfg_t cfg_q;
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_q <= '0;
    end else if (ce) begin
      cfg_q.path       <= path_sel; // RULE1
      cfg_q.pll_used   <= pll_used; // RULE2 RULE7
      cfg_q.doubler_en <= dbl_en;
      cfg_q.pre_div    <= pre_div; // RULE4
      cfg_q.fb_div     <= fbdiv_q; // RULE6
      cfg_q.cp_current <= {1'b0, cp_code};
    end
  end
  assign pll_cfg_out = cfg_q;

  // ----------------------------------------------------------------------
  // lock detector
  // ----------------------------------------------------------------------
  logic [10:0] run_q;
  logic        lock_q;
  wire         ld_dis    = ctrl_q[scpc_pkg::SCPC_LDDIS_BIT]; // RULE9
  wire [10:0]  run_need  = scpc_pkg::SCPC_RUN_128 << ctrl_q[scpc_pkg::SCPC_LDIV_LSB +: 2]; // RULE11
  wire         samp      = pfd_sample_in && !ld_dis; // RULE8
  wire [10:0]  run_inc   = (run_q < run_need) ? run_q + 11'h001 : run_q;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      run_q  <= 11'h000;
      lock_q <= 1'b0;
    end else if (ce) begin
      if (ld_dis) begin
        run_q  <= 11'h000;
        lock_q <= 1'b0;
      end else if (samp && !pfd_in_phase_in) begin
        run_q  <= 11'h000; // RULE17
        lock_q <= 1'b0; // RULE17
      end else if (samp) begin
        run_q  <= run_inc; // RULE10
        lock_q <= (run_inc >= run_need); // RULE10
      end
    end
  end
  assign pll_locked_out = lock_q;

  // ----------------------------------------------------------------------
  // stability timer
  // ----------------------------------------------------------------------
  // disabled detector: timer starts at once, software is expected to have zeroed it
  wire         tmr_go  = ld_dis || lock_q || !pll_used; // RULE12
  scpc_pkg::scpc_tmr_t tst_q;
  logic [15:0] pre_q;
  logic [19:0] ms_q;
  logic        stable_q;
  wire         ms_tick = (pre_q == 16'(scpc_pkg::SCPC_CYC_PER_MS - 1));

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tst_q    <= scpc_pkg::SCPC_TMR_IDLE;
      pre_q    <= 16'h0000;
      ms_q     <= 20'h00000;
      stable_q <= 1'b0;
    end else if (ce) begin
      case (tst_q)
        scpc_pkg::SCPC_TMR_IDLE: begin
          pre_q <= 16'h0000;
          ms_q  <= 20'h00000;
          if (timer_q == 20'h00000) begin
            tst_q    <= scpc_pkg::SCPC_TMR_DONE; // RULE16
            stable_q <= 1'b1;
          end else if (tmr_go) begin
            tst_q <= scpc_pkg::SCPC_TMR_RUN; // RULE16
          end
        end
        scpc_pkg::SCPC_TMR_RUN: begin
          if (!tmr_go) begin
            tst_q <= scpc_pkg::SCPC_TMR_IDLE;
          end else if (ms_tick) begin
            pre_q <= 16'h0000;
            ms_q  <= ms_q + 20'h00001;
            if (ms_q + 20'h00001 >= timer_q) begin
              tst_q    <= scpc_pkg::SCPC_TMR_DONE;
              stable_q <= 1'b1;
            end
          end else begin
            pre_q <= pre_q + 16'h0001;
          end
        end
        scpc_pkg::SCPC_TMR_DONE: begin
          // losing lock restarts the wait; zero timer stays stable
          if (!tmr_go && timer_q != 20'h00000) begin
            tst_q    <= scpc_pkg::SCPC_TMR_IDLE;
            stable_q <= 1'b0;
          end
        end
        default: begin
          tst_q <= scpc_pkg::SCPC_TMR_IDLE;
        end
      endcase
    end
  end
  assign sysclk_stable_out = stable_q;

  // ----------------------------------------------------------------------
  // interrupts: bit0 lock gained, bit1 lock lost, bit2 stable
  // ----------------------------------------------------------------------
  logic lock_d1_q;
  logic stab_d1_q;
  wire [2:0] irq_ev = {stable_q & ~stab_d1_q, lock_d1_q & ~lock_q, lock_q & ~lock_d1_q};
  wire [2:0] irq_clr = wr_ist ? reg_wdata_in[2:0] : 3'h0;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lock_d1_q  <= 1'b0;
      stab_d1_q  <= 1'b0;
      irq_stat_q <= 3'h0;
    end else if (ce) begin
      lock_d1_q  <= lock_q;
      stab_d1_q  <= stable_q;
      // a new event wins over a clear in the same cycle
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
    end
  end
  assign irq_out = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------------
  // read port: data in the cycle after the strobe
  // ----------------------------------------------------------------------
  wire [7:0] status_v = {5'h00, stable_q, lock_q, pll_used};
  wire [7:0] rd_mux =
    (reg_addr_in == scpc_pkg::SCPC_CTRL_OFF)             ? ctrl_q :
    (reg_addr_in == scpc_pkg::SCPC_FBDIV_OFF)            ? fbdiv_q :
    (reg_addr_in == scpc_pkg::SCPC_PATH_OFF)             ? path_q :
    (reg_addr_in == scpc_pkg::SCPC_TIMER_OFF)            ? timer_q[7:0] :
    (reg_addr_in == scpc_pkg::SCPC_TIMER_OFF + 12'h001)  ? timer_q[15:8] :
    (reg_addr_in == scpc_pkg::SCPC_TIMER_OFF + 12'h002)  ? {4'h0, timer_q[19:16]} :
    (reg_addr_in == scpc_pkg::SCPC_STATUS_OFF)           ? status_v :
    (reg_addr_in == scpc_pkg::SCPC_IRQ_STAT_OFF)         ? {5'h00, irq_stat_q} :
    (reg_addr_in == scpc_pkg::SCPC_IRQ_MASK_OFF)         ? {5'h00, irq_mask_q} : 8'h00;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_q <= 8'h00;
    end else if (ce) begin
      rdata_q <= reg_rd_in ? rd_mux : 8'h00;
    end
  end
  assign reg_rdata_out = rdata_q;

endmodule
`default_nettype wire

/* File: scpc_pfd_model.sv */
// phase detector sample source standing in for the multiplier pll
`timescale 1ns/1ps
`default_nettype none
module scpc_pfd_model (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        start_in,
  input  wire logic [10:0] len_in,
  input  wire logic        slow_in,
  input  wire logic        miss_in,
  output logic             sample_out,
  output logic             phase_out,
  output logic             busy_out
);
  logic [10:0] cnt_q;
  logic        gap_q;
  assign busy_out = (cnt_q != 11'h000) || sample_out;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q      <= 11'h000;
      gap_q      <= 1'b0;
      sample_out <= 1'b0;
      phase_out  <= 1'b0;
    end else if (start_in) begin
      cnt_q <= len_in;
    end else if (cnt_q != 11'h000 && !gap_q) begin
      cnt_q      <= cnt_q - 11'h001;
      gap_q      <= slow_in;
      sample_out <= 1'b1;
      phase_out  <= !(miss_in && cnt_q == 11'h001);
    end else begin
      gap_q      <= 1'b0;
      sample_out <= 1'b0;
      // idle level toggles so a stale flag never passes for a real sample
      phase_out  <= ~phase_out;
    end
  end
endmodule
`default_nettype wire

/* File: scpc_top_sva.sv */
// concurrent checks on the ports of the system clock pll control block
`timescale 1ns/1ps
`default_nettype none
module scpc_top_sva (
  input wire logic                    core_clk_in,
  input wire logic                    arst_n_in,
  input wire logic                    clk_en_in,
  input wire logic [11:0]             reg_addr_in,
  input wire logic [7:0]              reg_wdata_in,
  input wire logic                    reg_wr_in,
  input wire logic                    reg_rd_in,
  input wire logic [7:0]              reg_rdata_out,
  input wire logic                    pfd_sample_in,
  input wire logic                    pfd_in_phase_in,
  input wire scpc_pkg::scpc_pll_cfg_t pll_cfg_out,
  input wire logic                    pll_locked_out,
  input wire logic                    sysclk_stable_out,
  input wire logic                    irq_out
);
  logic [7:0]  ctrl_q, fb_q, path_q;
  logic [10:0] run_q;
  logic        up_q;
  wire         wr_en = reg_wr_in && clk_en_in;
  wire  [10:0] thr   = scpc_pkg::SCPC_RUN_128 << ctrl_q[1:0];
  // shadow copies let the checker know what the outputs should hold
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_q <= scpc_pkg::SCPC_CTRL_RST;
      fb_q   <= scpc_pkg::SCPC_FBDIV_RST;
      path_q <= scpc_pkg::SCPC_PATH_RST;
      run_q  <= 11'h000;
      up_q   <= 1'b0;
    end else if (clk_en_in) begin
      up_q <= 1'b1;
      if (wr_en && reg_addr_in == scpc_pkg::SCPC_CTRL_OFF) ctrl_q <= reg_wdata_in;
      if (wr_en && reg_addr_in == scpc_pkg::SCPC_FBDIV_OFF)
        fb_q <= (reg_wdata_in < scpc_pkg::SCPC_FB_MIN) ? scpc_pkg::SCPC_FB_MIN : reg_wdata_in;
      if (wr_en && reg_addr_in == scpc_pkg::SCPC_PATH_OFF && reg_wdata_in[1:0] != 2'h3)
        path_q <= reg_wdata_in;
      if (ctrl_q[2] || (pfd_sample_in && !pfd_in_phase_in)) run_q <= 11'h000;
      else if (pfd_sample_in && run_q != thr) run_q <= run_q + 11'h001;
    end
  end
  function automatic logic [3:0] band(input logic [7:0] fb);
    return fb < 8'h20 ? 4'h1 : fb < 8'h40 ? 4'h3 : fb < 8'h80 ? 4'h5 : 4'h7;
  endfunction
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_miss;
    pfd_sample_in && !pfd_in_phase_in && clk_en_in;
  endsequence
  sequence s_settled;
    up_q && $stable(ctrl_q) && $stable(fb_q) && $stable(path_q);
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data not zero outside read answer");
  a_ctrl_readback: assert property ($past(reg_rd_in && reg_addr_in == scpc_pkg::SCPC_CTRL_OFF)
    |-> reg_rdata_out == ctrl_q) else $error("control readback wrong");
  a_lock_run: assert property ($rose(pll_locked_out) |-> run_q == thr)
    else $error("lock declared at wrong run length");
  a_lock_drop: assert property (s_miss |=> !pll_locked_out)
    else $error("lock kept after out of phase sample");
  a_lock_disable: assert property (ctrl_q[2] ##1 ctrl_q[2] |-> !pll_locked_out)
    else $error("lock shown with detector disabled");
  a_cp_auto: assert property (s_settled ##0 !ctrl_q[6] |-> pll_cfg_out.cp_current == band(fb_q))
    else $error("automatic pump current wrong");
  a_cp_manual: assert property (s_settled ##0 ctrl_q[6]
    |-> pll_cfg_out.cp_current == {1'b0, ctrl_q[5:3]}) else $error("manual pump current wrong");
  a_fb_floor: assert property (s_settled |-> pll_cfg_out.fb_div == fb_q)
    else $error("feedback divider wrong");
  a_prediv_map: assert property (s_settled |-> pll_cfg_out.pre_div == (4'h1 << path_q[3:2])
    && pll_cfg_out.path == path_q[1:0]
    && pll_cfg_out.doubler_en == (path_q[4] && path_q[1:0] == 2'h1))
    else $error("path or pre divider wrong");
  a_path_used: assert property (up_q && pll_cfg_out.path != scpc_pkg::SCPC_PATH_DIRECT
    |-> pll_cfg_out.pll_used) else $error("synthesized path bypasses pll");
endmodule
`default_nettype wire

/* File: scpc_top_test.sv */
// self-checking testbench for the system clock pll control block
`timescale 1ns/1ps
`default_nettype none
module scpc_top_test;
  logic core_clk_in = 1'b0, arst_n_in = 1'b0, clk_en_in = 1'b1;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, m_start = 1'b0, m_slow = 1'b0, m_miss = 1'b0;
  logic [11:0] reg_addr_in = 12'h000;
  logic [7:0]  reg_wdata_in = 8'h00, reg_rdata_out, d;
  logic [10:0] m_len = 11'h000;
  logic pfd_sample_in, pfd_in_phase_in, pll_locked_out, sysclk_stable_out, irq_out, m_busy;
  logic rd_d = 1'b0;
  scpc_pkg::scpc_pll_cfg_t pll_cfg_out;
  logic [7:0] exp_q[$];
  int mismatches = 0, n_checks = 0, cyc = 0;
  scpc_top scpc_top_inst (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
    .clk_en_in(clk_en_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .pfd_sample_in(pfd_sample_in), .pfd_in_phase_in(pfd_in_phase_in),
    .pll_cfg_out(pll_cfg_out), .pll_locked_out(pll_locked_out),
    .sysclk_stable_out(sysclk_stable_out), .irq_out(irq_out));
  scpc_pfd_model scpc_pfd_model_inst (.clk_in(core_clk_in), .arst_n_in(arst_n_in),
    .start_in(m_start), .len_in(m_len), .slow_in(m_slow), .miss_in(m_miss),
    .sample_out(pfd_sample_in), .phase_out(pfd_in_phase_in), .busy_out(m_busy));
  always #10 core_clk_in = ~core_clk_in;
  task automatic complete_run();
    if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge core_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= v;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge core_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    exp_q.push_back(e);
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge core_clk_in);
  endtask
  task automatic irq_is(input logic e);
    @(negedge core_clk_in);
    chk8({7'h00, irq_out}, {7'h00, e});
  endtask
  // samples arrive every cycle or every other cycle at random
  task automatic send(input logic [10:0] n, input logic miss);
    @(posedge core_clk_in);
    m_start <= 1'b1;
    m_len <= n;
    m_miss <= miss;
    m_slow <= 1'($urandom);
    @(posedge core_clk_in);
    m_start <= 1'b0;
    @(posedge core_clk_in);
    while (m_busy) @(posedge core_clk_in);
    repeat (2) @(posedge core_clk_in);
  endtask
  always @(posedge core_clk_in) rd_d <= reg_rd_in;
  always @(negedge core_clk_in) if (rd_d) chk8(reg_rdata_out, exp_q.pop_front());
  // the longest lock runs need a few thousand cycles
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc > 40000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(32'h41340AF1));
    repeat (8) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    rd(scpc_pkg::SCPC_CTRL_OFF, 8'h18);
    rd(scpc_pkg::SCPC_FBDIV_OFF, 8'h28);
    rd(12'h1FF, 8'h00);
    wr(scpc_pkg::SCPC_FBDIV_OFF, 8'h03);
    rd(scpc_pkg::SCPC_FBDIV_OFF, 8'h06);
    wr(scpc_pkg::SCPC_FBDIV_OFF, 8'hFF);
    rd(scpc_pkg::SCPC_FBDIV_OFF, 8'hFF);
    // a write while the clock enable is low must not land
    @(posedge core_clk_in) clk_en_in <= 1'b0;
    wr(scpc_pkg::SCPC_FBDIV_OFF, 8'h10);
    clk_en_in <= 1'b1;
    rd(scpc_pkg::SCPC_FBDIV_OFF, 8'hFF);
    for (int i = 0; i < 3; i++) begin
      d = (8'($urandom) & 8'h1C) | 8'(i);
      wr(scpc_pkg::SCPC_PATH_OFF, d);
      rd(scpc_pkg::SCPC_PATH_OFF, d);
      rd(scpc_pkg::SCPC_STATUS_OFF, {7'h00, (i != 0) || (d[3:2] != 2'h0)});
    end
    wr(scpc_pkg::SCPC_PATH_OFF, 8'h03);
    rd(scpc_pkg::SCPC_PATH_OFF, d);
    for (int k = 0; k < 8; k++) begin
      wr(scpc_pkg::SCPC_CTRL_OFF, {2'h1, 3'(k), 3'h0});
      repeat (2) @(negedge core_clk_in);
      chk8({4'h0, pll_cfg_out.cp_current}, 8'(k));
      wr(scpc_pkg::SCPC_CTRL_OFF, {2'h0, 3'(k), 3'h0});
      repeat (2) @(negedge core_clk_in);
      chk8({4'h0, pll_cfg_out.cp_current}, 8'h07);
    end
    wr(scpc_pkg::SCPC_IRQ_MASK_OFF, 8'h07);
    wr(scpc_pkg::SCPC_CTRL_OFF, 8'h03);
    send(11'd1023, 1'b0);
    rd(scpc_pkg::SCPC_STATUS_OFF, 8'h01);
    send(11'd1, 1'b0);
    rd(scpc_pkg::SCPC_STATUS_OFF, 8'h03);
    irq_is(1'b1);
    wr(scpc_pkg::SCPC_IRQ_MASK_OFF, 8'h00);
    irq_is(1'b0);
    wr(scpc_pkg::SCPC_IRQ_STAT_OFF, 8'h07);
    wr(scpc_pkg::SCPC_IRQ_MASK_OFF, 8'h07);
    irq_is(1'b0);
    send(11'd1, 1'b1);
    rd(scpc_pkg::SCPC_STATUS_OFF, 8'h01);
    irq_is(1'b1);
    for (int b = 0; b < 3; b++) wr(scpc_pkg::SCPC_TIMER_OFF + 12'(b), 8'h00);
    wr(scpc_pkg::SCPC_CTRL_OFF, 8'h07);
    send(11'd200, 1'b0);
    rd(scpc_pkg::SCPC_STATUS_OFF, 8'h05);
    complete_run();
  end
endmodule
bind scpc_top scpc_top_sva scpc_top_sva_inst (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
  .clk_en_in(clk_en_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .pfd_sample_in(pfd_sample_in), .pfd_in_phase_in(pfd_in_phase_in),
  .pll_cfg_out(pll_cfg_out), .pll_locked_out(pll_locked_out),
  .sysclk_stable_out(sysclk_stable_out), .irq_out(irq_out));
`default_nettype wire
